// File: verilog/igfb_pkg.sv
/*
 * constants and carrier types for the input glitch filter bank.
 * assumes one 20 MHz system clock and no software-visible registers.
 */
// Function
// - sixteen inputs, low and high groups of eight, each filtered and interrupt capable.
// - any filtered input can trigger an encoder position capture on a chosen edge.
// - setting is zero after reset, so no filtering until changed.
// - level accepted only if it lasts longer than filter time; shorter pulses dropped.
// - accepted change appears at output delayed by the filter time.
// - setting zero passes inputs through unchanged, no rejection, no filter delay.
package igfb_pkg;

   // ****************************************
   // sizes and timing
   // ****************************************
   localparam int unsigned IGFB_GROUP_W = 8;
   localparam int unsigned IGFB_NUM_IN = 2 * IGFB_GROUP_W;
   localparam int unsigned IGFB_CLK_HZ = 20000000;
   localparam int unsigned IGFB_STEP_US = 31;
   localparam int unsigned IGFB_STEP_CYC = (IGFB_STEP_US * (IGFB_CLK_HZ / 1000000));
   localparam int unsigned IGFB_TB_W = 10;
   localparam logic [7:0] IGFB_FILT_RST = 8'h00;

   // ****************************************
   // carriers
   // ****************************************
   typedef struct packed {
      logic [IGFB_GROUP_W-1:0] high_grp;
      logic [IGFB_GROUP_W-1:0] low_grp;
   } igfb_points_t;

   typedef enum logic [1:0] {
      IGFB_EDGE_RISE = 2'h0,
      IGFB_EDGE_FALL = 2'h1,
      IGFB_EDGE_BOTH = 2'h3,
      IGFB_EDGE_NONE = 2'h2
   } igfb_edge_t;

endpackage

// File: verilog/igfb_top.sv
/*
 * sixteen-input glitch filter bank with interrupt and capture triggers.
 * assumes asynchronous field inputs, a 20 MHz clk_sys, and that the
 * filter setting and capture selection are static control inputs from
 * same-domain logic; the capture datapath samples encoder position
 * on capture_strobe.
 * irq_events and capture_strobe follow a filtered change by one cycle;
 * the interrupt controller is expected to latch the one-cycle pulses.
 */
`timescale 1ns/1ps
module igfb_top #(
   parameter int unsigned POS_W = 32
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input igfb_pkg::igfb_points_t input_points,
   input wire logic [7:0] filter_setting,
   input wire logic [igfb_pkg::IGFB_NUM_IN-1:0] irq_enable,
   input wire logic [3:0] capture_select,
   input igfb_pkg::igfb_edge_t capture_edge,
   input wire logic [POS_W-1:0] encoder_position,
   output igfb_pkg::igfb_points_t filtered_points,
   output logic [igfb_pkg::IGFB_NUM_IN-1:0] irq_events,
   output logic capture_strobe,
   output logic [POS_W-1:0] captured_position
);
   import igfb_pkg::*;

   // ****************************************
   // edge qualification
   // ****************************************
   // shared by the interrupt pulses and the capture trigger
   function automatic logic edge_hit(logic was, logic now, igfb_edge_t mode);
      logic hit;
      hit = 1'b0;
      unique case (mode)
         IGFB_EDGE_RISE: hit = !was && now;
         IGFB_EDGE_FALL: hit = was && !now;
         IGFB_EDGE_BOTH: hit = was != now;
         IGFB_EDGE_NONE: hit = 1'b0;
      endcase
      return hit;
   endfunction

   // ****************************************
   // reset release
   // ****************************************
   logic [1:0] rst_sync_reg;
   logic [1:0] rst_sync_next;
   logic rst_int_n;

   // ones shift in after the pin lets go, so release is clock aligned
   always_comb begin
      rst_sync_next = {rst_sync_reg[0], 1'b1};
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= rst_sync_next;
      end
   end
   assign rst_int_n = rst_sync_reg[1];

   // ****************************************
   // input synchronisers
   // ****************************************
   logic [IGFB_NUM_IN-1:0] meta_reg;
   logic [IGFB_NUM_IN-1:0] meta_next;
   logic [IGFB_NUM_IN-1:0] sync_reg;
   logic [IGFB_NUM_IN-1:0] sync_next;

   // only the second stage is read by the filters
   always_comb begin
      meta_next = input_points;
      sync_next = meta_reg;
   end

   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= meta_next;
         sync_reg <= sync_next;
      end
   end

   // ****************************************
   // 31 us timebase
   // ****************************************
   logic [IGFB_TB_W-1:0] tb_cnt_reg;
   logic [IGFB_TB_W-1:0] tb_cnt_next;
   logic tick;

   // free running; all sixteen filters share one step so that
   // a pulse may be judged up to one step late, never early
   always_comb begin
      tick = (tb_cnt_reg == IGFB_TB_W'(IGFB_STEP_CYC - 1));
      tb_cnt_next = tick ? '0 : tb_cnt_reg + IGFB_TB_W'(1);
   end

   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         tb_cnt_reg <= '0;
      end else begin
         tb_cnt_reg <= tb_cnt_next;
      end
   end

   // ****************************************
   // per-input filters
   // ****************************************
   // a step counts once the new level has been seen at a tick; reaching
   // the setting plus one step guarantees a length over the filter time.
   // the output takes the synchronised level at the accepting tick, so it trails by the delay.
   logic [IGFB_NUM_IN-1:0] out_reg;
   logic [IGFB_NUM_IN-1:0] out_next;
   logic [8:0] cnt_reg [IGFB_NUM_IN];
   logic [8:0] cnt_next [IGFB_NUM_IN];
   logic [7:0] filt_reg;
   logic [7:0] filt_next;

   // the setting is only taken at a tick, so a change never cuts a
   // step short for a counter already running
   always_comb begin
      filt_next = filt_reg;
      if (tick) begin
         filt_next = filter_setting;
      end
      for (int i = 0; i < IGFB_NUM_IN; i++) begin
         out_next[i] = out_reg[i];
         cnt_next[i] = cnt_reg[i];
         if (filt_reg == 8'h00) begin
            out_next[i] = sync_reg[i];
            cnt_next[i] = 9'h000;
         end else if (sync_reg[i] == out_reg[i]) begin
            cnt_next[i] = 9'h000;
         end else if (tick) begin
            if (cnt_reg[i] >= {1'b0, filt_reg}) begin
               out_next[i] = sync_reg[i];
               cnt_next[i] = 9'h000;
            end else begin
               cnt_next[i] = cnt_reg[i] + 9'h001;
            end
         end
      end
   end

   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         out_reg <= '0;
         filt_reg <= IGFB_FILT_RST;
         for (int i = 0; i < IGFB_NUM_IN; i++) begin
            cnt_reg[i] <= 9'h000;
         end
      end else begin
         out_reg <= out_next;
         filt_reg <= filt_next;
         for (int i = 0; i < IGFB_NUM_IN; i++) begin
            cnt_reg[i] <= cnt_next[i];
         end
      end
   end

   // ****************************************
   // interrupt and capture triggers
   // ****************************************
   logic [IGFB_NUM_IN-1:0] prev_reg;
   logic [IGFB_NUM_IN-1:0] prev_next;
   logic [IGFB_NUM_IN-1:0] irq_reg;
   logic [IGFB_NUM_IN-1:0] irq_next;
   logic cap_reg;
   logic cap_next;
   logic [POS_W-1:0] pos_reg;
   logic [POS_W-1:0] pos_next;
   logic sel_prev;
   logic sel_now;

   // triggers look only at the filtered levels, never the raw pins
   always_comb begin
      prev_next = out_reg;
      for (int i = 0; i < IGFB_NUM_IN; i++) begin
         irq_next[i] = edge_hit(prev_reg[i], out_reg[i], IGFB_EDGE_BOTH)
            && irq_enable[i];
      end
      sel_prev = prev_reg[capture_select];
      sel_now = out_reg[capture_select];
      cap_next = edge_hit(sel_prev, sel_now, capture_edge);
      pos_next = cap_next ? encoder_position : pos_reg;
   end

   always_ff @(posedge clk_sys or negedge rst_int_n) begin
      if (!rst_int_n) begin
         prev_reg <= '0;
         irq_reg <= '0;
         cap_reg <= 1'b0;
         pos_reg <= '0;
      end else begin
         prev_reg <= prev_next;
         irq_reg <= irq_next;
         cap_reg <= cap_next;
         pos_reg <= pos_next;
      end
   end

   assign filtered_points = out_reg;
   assign irq_events = irq_reg;
   assign capture_strobe = cap_reg;
   assign captured_position = pos_reg;

endmodule

// File: verification/igfb_top_properties.sv
/* port properties of the filter bank.
   assumes one clk_sys domain; bound below. */
`timescale 1ns/1ps
module igfb_top_properties import igfb_pkg::*; #(parameter int unsigned POS_W = 32) (
   input wire logic clk_sys, rst_n, capture_strobe,
   input igfb_points_t input_points, filtered_points,
   input wire logic [7:0] filter_setting,
   input wire logic [15:0] irq_enable, irq_events,
   input wire logic [3:0] capture_select,
   input igfb_edge_t capture_edge,
   input wire logic [POS_W-1:0] encoder_position, captured_position);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire logic s = filtered_points[capture_select];
   sequence quiet; filtered_points == 0 && irq_events == 0 && !capture_strobe; endsequence
   rst_quiet_a: assert property ($rose(rst_n) |-> quiet [*2]) else $error("reset");
   pass_thru_a: assert property (filter_setting == 0 && $past(filter_setting, 700) == 0
      |-> filtered_points == $past(input_points, 3)) else $error("pass");
   irq_event_a: assert property ($past(irq_enable) == $past(irq_enable, 2) |-> irq_events ==
      (($past(filtered_points) ^ $past(filtered_points, 2)) & $past(irq_enable)))
      else $error("irq");
   cap_edge_a: assert property ($past(capture_select) == $past(capture_select, 2) |->
      capture_strobe == ($past(s) != $past(s, 2) && $past(capture_edge) != IGFB_EDGE_NONE &&
      ($past(capture_edge) == IGFB_EDGE_BOTH ||
      ($past(capture_edge) == IGFB_EDGE_RISE) == $past(s)))) else $error("cap");
   cap_none_a: assert property (capture_edge == IGFB_EDGE_NONE [*3] |-> !capture_strobe)
      else $error("none");
   cap_pos_a: assert property (capture_strobe |-> captured_position ==
      $past(encoder_position)) else $error("position");
   pos_hold_a: assert property (!capture_strobe |-> $stable(captured_position))
      else $error("hold");
   min_hold_a: assert property (filter_setting != 0 && filter_setting ==
      $past(filter_setting, 1300) |-> ((filtered_points ^ $past(filtered_points)) &
      (filtered_points ^ $past(input_points, 620))) == 0) else $error("short");
endmodule
bind igfb_top igfb_top_properties #(.POS_W(POS_W)) u_props (.*);

// File: verification/igfb_field_model.sv
/* field switches driving the raw input levels.
   assumes the bench picks each level, glitches included. */
`timescale 1ns/1ps
module igfb_field_model import igfb_pkg::*; (
   input wire logic clk_sys,
   input wire logic [15:0] level,
   output igfb_points_t input_points = '0);
   always @(posedge clk_sys) input_points <= level;
endmodule

// File: verification/tb_igfb_top.sv
/* self-checking bench of the filter bank.
   assumes the bound checker and the field model. */
`timescale 1ns/1ps
module tb_igfb_top;
   import igfb_pkg::*;
   logic clk_sys = 0, rst_n = 0, capture_strobe, chk_on = 0;
   logic [15:0] level = '0, irq_enable = '0, irq_events, hist [6];
   logic [7:0] filter_setting = 8'h00;
   logic [3:0] capture_select = 4'h0;
   logic [31:0] encoder_position = '0, captured_position, rnd = 32'h18241;
   igfb_edge_t capture_edge = IGFB_EDGE_RISE;
   igfb_points_t input_points, filtered_points;
   int n_errors = 0, compares = 0, cyc = 0;
   igfb_field_model field (.*);
   igfb_top uut (.*);
   initial forever #25 clk_sys = ~clk_sys;
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic cap_exp(logic p, logic n, igfb_edge_t e);
      return (e == IGFB_EDGE_BOTH && p != n) || (e == IGFB_EDGE_RISE && !p && n) ||
         (e == IGFB_EDGE_FALL && p && !n);
   endfunction
   task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("mismatches %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic step(int n);
      repeat (n) @(posedge clk_sys);
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      encoder_position <= encoder_position + 32'h1;
      for (int i = 5; i > 0; i--) hist[i] <= hist[i-1];
      hist[0] <= input_points;
      if (cyc > 10000) n_errors++;
      if (cyc > 10000) final_report();
   end
   always @(negedge clk_sys) if (chk_on) begin
      chk("filtered", filtered_points, hist[2]);
      chk("irq", irq_events, (hist[3] ^ hist[4]) & irq_enable);
      chk("strobe", capture_strobe, cap_exp(hist[4][capture_select], hist[3][capture_select],
         capture_edge));
      if (capture_strobe) chk("position", captured_position, encoder_position - 32'h1);
   end
   initial begin
      step(2);
      rst_n <= 1'b1;
      step(8);
      chk_on = 1;
      for (int e = 0; e < 4; e++) begin
         step(8);
         rnd = lfsr(rnd);
         capture_edge <= igfb_edge_t'(e);
         irq_enable <= rnd[15:0];
         capture_select <= rnd[19:16];
         repeat (100) begin
            step(1);
            rnd = lfsr(rnd);
            level <= rnd[15:0];
         end
      end
      chk_on = 0;
      level <= '0;
      filter_setting <= 8'h01;
      step(1300);
      level <= 16'h0001;
      step(300);
      level <= '0;
      step(1300);
      #1 chk("short", filtered_points, '0);
      level <= 16'h0001;
      step(600);
      #1 chk("early", filtered_points, '0);
      step(700);
      #1 chk("long", filtered_points, 32'h1);
      final_report();
   end
endmodule
